// ==== logic/lo_div_pkg.sv ====
/*
  constants and types shared by the quadrature lo divider device end and its controller end.
  assumes both ends run on the same 20 MHz system clock; the quad-rate lo clock is a signal.
*/
//
// Behaviour
// R1 - divide quad-rate lo by four for I/Q
// R2 - sixteen phase steps of 22.5 degrees each
// R3 - reset forces divider to known state
// R4 - divider may power up in any state
// R5 - I and Q always a quarter cycle apart
// R6 - all channels share one internal lo
// R7 - controller holds reset high 20 ns minimum
// R8 - divider restarts on next lo rising edge
// R9 - controller releases reset on all devices together
// R10 - controller changes reset on lo falling edges
// R11 - phase code steps rotation from code zero
// R12 - channel enable bit activates its demodulator
// R13 - controller runs sync check with code zero
// R14 - divider is two-bit counter held in reset
package lo_div_pkg;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned clk_mhz = 20;
  localparam int unsigned reset_min_ns = 20;
  localparam int unsigned reset_min_cycles =
    ((reset_min_ns * clk_mhz + 999) / 1000) < 1 ? 1 : ((reset_min_ns * clk_mhz + 999) / 1000);
  // ****************************************************
  // fields and reset values
  // ****************************************************
  localparam int unsigned phase_code_width = 4;
  localparam int unsigned phase_steps = 16;
  localparam int unsigned enable_bit_pos = 4;
  localparam logic [1:0] div_reset_state = 2'h0;
  localparam logic [3:0] sync_check_code = 4'h0;
  localparam int unsigned num_channels = 8;
  typedef enum {ctl_idle, ctl_setup, ctl_wait_fall, ctl_hold, ctl_release, ctl_done} ctl_state_type;
endpackage : lo_div_pkg

// ==== logic/lo_div_if.sv ====
/*
  link between the controller end and the divider device end.
  assumes a shared system clock; lo_quad_rate_clock is carried as a data signal.
*/
`timescale 1ns/10ps
interface lo_div_if
  import lo_div_pkg::*;
#(
  parameter int unsigned channels = num_channels
);
  logic lo_quad_rate_clock;
  logic div_reset;
  logic [channels*phase_code_width-1:0] phase_codes;
  logic [channels-1:0] channel_enables;
  modport device (
    input lo_quad_rate_clock,
    input div_reset,
    input phase_codes,
    input channel_enables
  );
  modport controller (
    output lo_quad_rate_clock,
    output div_reset,
    output phase_codes,
    output channel_enables
  );
endinterface : lo_div_if

// ==== logic/lo_divider_device.sv ====
/*
  device end: samples the quad-rate lo and reset pins, divides by four to I/Q,
  and applies per-channel phase rotation and enable.
  assumes the lo toggles slower than half the system clock, so that every lo
  level lasts at least two system clocks and the edge detector sees each edge.
  assumes reset and lo come from the controller end as levels; both pass two
  flops, so a reset level shorter than one system clock may go unseen.
*/
`timescale 1ns/10ps
// ****************************************************
// per-channel phase rotator
// ****************************************************
// one channel: adds its code to the shared count in 22.5 degree steps and
// registers the rotated I and Q; a disabled channel holds both low
module lo_phase_rotator
  import lo_div_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_count,
  input wire logic [phase_code_width-1:0] i_code,
  input wire logic i_enable,
  output logic o_i,
  output logic o_q
);
  logic [3:0] ph;
  logic i_r, i_nxt, q_r, q_nxt;

  // rotated phase: the count gives the coarse quarter, the code the fine step
  always_comb
  begin
    ph = {i_count, 2'h0} + i_code; // [R2] [R11]
    i_nxt = i_enable & ph[3]; // [R12]
    q_nxt = i_enable & (ph[3] ^ ph[2]); // quarter-cycle offset [R5] [R12]
  end

  // register the channel outputs on the same edge as the shared counter
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      i_r <= 1'b0;
      q_r <= 1'b0;
    end
    else
    begin
      i_r <= i_nxt;
      q_r <= q_nxt;
    end
  end

  assign o_i = i_r;
  assign o_q = q_r;
endmodule : lo_phase_rotator

// ****************************************************
// device end
// ****************************************************
module lo_divider_device
  import lo_div_pkg::*;
#(
  parameter int unsigned channels = num_channels
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  lo_div_if.device link,
  output logic o_lo_i,
  output logic o_lo_q,
  output logic [channels-1:0] o_ch_i,
  output logic [channels-1:0] o_ch_q,
  output logic [1:0] o_div_state
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic lo_s1_r, lo_s2_r, lo_s3_r;
  logic rst_s1_r, rst_s2_r;
  logic [1:0] div_r, div_nxt;
  logic lo_i_r, lo_i_nxt, lo_q_r, lo_q_nxt;
  logic lo_rise;

  // two flops per pin, third flop for lo edge detection
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lo_s1_r <= 1'b0;
      lo_s2_r <= 1'b0;
      lo_s3_r <= 1'b0;
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      lo_s1_r <= link.lo_quad_rate_clock;
      lo_s2_r <= lo_s1_r;
      lo_s3_r <= lo_s2_r;
      rst_s1_r <= link.div_reset;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ****************************************************
  // lo edge detection
  // ****************************************************
  // rising edge seen in the same clock that the synchronised level goes high;
  // the third flop idles low like the pin, so no false edge follows reset
  assign lo_rise = lo_s2_r & ~lo_s3_r;

  // ****************************************************
  // divider and phase rotation
  // ****************************************************
  // counter held while reset high, steps once per detected lo rising edge;
  // holding it is what lines up dividers that woke up in different states
  always_comb
  begin
    div_nxt = div_r;
    if (rst_s2_r)
      div_nxt = div_reset_state; // [R3] [R14]
    else if (lo_rise)
      div_nxt = div_r + 2'h1; // [R1] [R8]
  end

  // register the counter; power-up state is arbitrary in silicon, zero here [R4]
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      div_r <= div_reset_state;
    else
      div_r <= div_nxt;
  end

  // ****************************************************
  // quadrature decode
  // ****************************************************
  // I from the upper count bit, Q from the gray step between the bits, so the
  // two stay a quarter of an lo cycle apart whatever the starting state
  always_comb
  begin
    lo_i_nxt = div_nxt[1]; // [R1]
    lo_q_nxt = div_nxt[1] ^ div_nxt[0]; // quarter-cycle offset [R5]
  end

  // register I and Q on the same edge as the counter
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lo_i_r <= 1'b0;
      lo_q_r <= 1'b0;
    end
    else
    begin
      lo_i_r <= lo_i_nxt;
      lo_q_r <= lo_q_nxt;
    end
  end

  // ****************************************************
  // channels
  // ****************************************************
  // every channel rotates the same next count, so channels of one device
  // cannot drift apart and need no reset among themselves [R6]
  for (genvar c = 0; c < channels; c++)
  begin : g_chan
    lo_phase_rotator lo_phase_rotator_i (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_count(div_nxt),
      .i_code(link.phase_codes[c*phase_code_width +: phase_code_width]),
      .i_enable(link.channel_enables[c]),
      .o_i(o_ch_i[c]),
      .o_q(o_ch_q[c])
    );
  end

  assign o_lo_i = lo_i_r;
  assign o_lo_q = lo_q_r;
  assign o_div_state = div_r;
endmodule : lo_divider_device

// ==== logic/lo_divider_controller.sv ====
/*
  controller end: makes the quad-rate lo by dividing the system clock, drives codes
  and enables, and issues a reset pulse aligned to lo falling edges.
  assumes one controller fans out to every device of the array.
*/
`timescale 1ns/10ps
module lo_divider_controller
  import lo_div_pkg::*;
#(
  parameter int unsigned channels = num_channels,
  parameter int unsigned lo_half_cycles = 2,
  parameter int unsigned hold_lo_periods = 1
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sync_start,
  input wire logic i_sync_check,
  input wire logic [channels*phase_code_width-1:0] i_phase_codes,
  input wire logic [channels-1:0] i_channel_enables,
  lo_div_if.controller link,
  output logic o_busy,
  output logic o_done
);
  // ****************************************************
  // lo generation
  // ****************************************************
  logic [7:0] half_cnt_r, half_cnt_nxt;
  logic lo_r, lo_nxt;
  logic lo_fall;

  // toggle lo every lo_half_cycles system clocks
  always_comb
  begin
    lo_fall = 1'b0;
    lo_nxt = lo_r;
    half_cnt_nxt = half_cnt_r + 8'h1;
    if (half_cnt_r == 8'(lo_half_cycles - 1))
    begin
      half_cnt_nxt = 8'h0;
      lo_nxt = ~lo_r;
      lo_fall = lo_r;
    end
  end

  // ****************************************************
  // reset sequencing
  // ****************************************************
  ctl_state_type st_r, st_nxt;
  logic rst_r, rst_nxt, done_r, done_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic [channels*phase_code_width-1:0] codes_r, codes_nxt;
  logic [channels-1:0] en_r, en_nxt;
  logic check_r, check_nxt;

  // program codes, then raise and drop reset on lo falling edges
  always_comb
  begin
    st_nxt = st_r;
    rst_nxt = rst_r;
    done_nxt = 1'b0;
    hold_nxt = hold_r;
    check_nxt = check_r;
    codes_nxt = check_r ? {channels{sync_check_code}} : i_phase_codes; // [R13]
    en_nxt = check_r ? '1 : i_channel_enables; // [R13]
    case (st_r)
      ctl_idle:
        if (i_sync_start)
        begin
          check_nxt = i_sync_check;
          st_nxt = ctl_setup;
        end
      ctl_setup:
        st_nxt = ctl_wait_fall;
      ctl_wait_fall:
        if (lo_fall)
        begin
          rst_nxt = 1'b1; // [R10]
          hold_nxt = 8'h0;
          st_nxt = ctl_hold;
        end
      ctl_hold:
        if (lo_fall)
        begin
          hold_nxt = hold_r + 8'h1;
          if (hold_r >= 8'(hold_lo_periods - 1))
          begin
            rst_nxt = 1'b0; // common release on a falling edge [R9] [R10]
            st_nxt = ctl_release;
          end
        end
      ctl_release:
        begin
          done_nxt = 1'b1;
          st_nxt = ctl_done;
        end
      ctl_done:
        begin
          check_nxt = 1'b0;
          st_nxt = ctl_idle;
        end
      default:
        st_nxt = ctl_idle;
    endcase
    // busy follows the next state, so the registered flag tracks the state register
    busy_nxt = (st_nxt != ctl_idle);
  end

  // one full lo period high is at least 4 clocks, above reset_min_cycles [R7]
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      half_cnt_r <= 8'h0;
      lo_r <= 1'b0;
      st_r <= ctl_idle;
      rst_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      hold_r <= 8'h0;
      codes_r <= '0;
      en_r <= '0;
      check_r <= 1'b0;
    end
    else
    begin
      half_cnt_r <= half_cnt_nxt;
      lo_r <= lo_nxt;
      st_r <= st_nxt;
      rst_r <= rst_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      codes_r <= codes_nxt;
      en_r <= en_nxt;
      check_r <= check_nxt;
    end
  end

  assign link.lo_quad_rate_clock = lo_r;
  assign link.div_reset = rst_r;
  assign link.phase_codes = codes_r;
  assign link.channel_enables = en_r;
  assign o_busy = busy_r;
  assign o_done = done_r;
endmodule : lo_divider_controller

// ==== test/lo_div_asserts.sv ====
/*
  checker for the lo divider link and the device outputs.
  assumes one clock and the default lo rate of four clocks.
*/
`timescale 1ns/10ps
module lo_div_asserts
  import lo_div_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic lo_quad_rate_clock,
  input wire logic div_reset,
  input wire logic [num_channels*phase_code_width-1:0] phase_codes,
  input wire logic [num_channels-1:0] channel_enables,
  input wire logic o_lo_i,
  input wire logic o_lo_q,
  input wire logic [num_channels-1:0] o_ch_i,
  input wire logic [num_channels-1:0] o_ch_q,
  input wire logic [1:0] o_div_state
);
  // phase of channel 0 taken from the shared counter
  logic [3:0] ph0;
  assign ph0 = {o_div_state, 2'h0} + phase_codes[3:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ****************************************************
  // properties
  // ****************************************************
  a_lo_half: assert property ($changed(lo_quad_rate_clock) |=>
    $stable(lo_quad_rate_clock)) else $error("lo half period short");
  a_reset_on_fall: assert property ($changed(div_reset) |->
    !lo_quad_rate_clock) else $error("reset moved while lo high");
  a_reset_hold: assert property ($rose(div_reset) |=> div_reset)
    else $error("reset pulse short");
  a_release_before: assert property ($fell(div_reset) |->
    !lo_quad_rate_clock ##1 !lo_quad_rate_clock) else $error("release too near lo rise");
  a_iq_pair: assert property (o_lo_q == (o_lo_i ^ o_div_state[0]))
    else $error("q not a quarter from i");
  a_i_decode: assert property (o_lo_i == o_div_state[1])
    else $error("i not from counter");
  a_reset_held: assert property (div_reset [*4] |->
    o_div_state == div_reset_state) else $error("counter not held");
  a_restart_bound: assert property ($fell(div_reset) |->
    ##[1:12] o_div_state == 2'h1) else $error("no restart");
  a_count_step: assert property ($changed(o_div_state) |->
    o_div_state == $past(o_div_state) + 2'h1 || o_div_state == div_reset_state)
    else $error("counter skipped");
  a_ch_i_phase: assert property ($changed(o_div_state) && $stable(phase_codes)
    |-> o_ch_i[0] == ($past(channel_enables[0]) & ph0[3])) else $error("channel i phase");
  a_ch_q_phase: assert property ($changed(o_div_state) && $stable(phase_codes)
    |-> o_ch_q[0] == ($past(channel_enables[0]) & (ph0[3] ^ ph0[2])))
    else $error("channel q phase");
endmodule : lo_div_asserts

// ==== test/testbench.sv ====
/*
  self-checking bench joining controller and device ends.
  assumes the default parameters of both ends.
*/
`timescale 1ns/10ps
module testbench
  import lo_div_pkg::*;
;
  // ****************************************************
  // signals and instances
  // ****************************************************
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_sync_start = 1'b0;
  logic i_sync_check = 1'b0;
  logic [31:0] i_phase_codes = 32'h0;
  logic [7:0] i_channel_enables = 8'h0;
  logic o_busy, o_done, o_lo_i, o_lo_q;
  logic [7:0] o_ch_i, o_ch_q;
  logic [1:0] o_div_state;
  logic [31:0] cap_codes;
  logic [7:0] cap_en;
  int err_total = 0;
  int checks = 0;
  lo_div_if link_if ();
  lo_divider_controller lo_divider_controller_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sync_start(i_sync_start), .i_sync_check(i_sync_check), .link(link_if),
    .i_phase_codes(i_phase_codes), .i_channel_enables(i_channel_enables),
    .o_busy(o_busy), .o_done(o_done));
  lo_divider_device lo_divider_device_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .link(link_if), .o_lo_i(o_lo_i), .o_lo_q(o_lo_q), .o_ch_i(o_ch_i),
    .o_ch_q(o_ch_q), .o_div_state(o_div_state));
  lo_div_asserts lo_div_asserts_i (.i_clk, .i_resetn, .o_lo_i, .o_lo_q, .o_ch_i,
    .o_ch_q, .o_div_state, .lo_quad_rate_clock(link_if.lo_quad_rate_clock),
    .div_reset(link_if.div_reset), .phase_codes(link_if.phase_codes),
    .channel_enables(link_if.channel_enables));
  // clock of 50 ns
  initial
  begin
    forever #25 i_clk = ~i_clk;
  end
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : cmp
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // pulse start, catch the link while reset is high, wait for done
  task automatic run_sync(input logic chk);
    int n;
    n = 0;
    // a start raised while the last sequence winds down would be refused
    while (o_busy !== 1'b0 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    i_sync_check = chk;
    i_sync_start = 1'b1;
    @(negedge i_clk);
    i_sync_start = 1'b0;
    cmp(o_busy, 1'b1);
    while (o_done !== 1'b1 && n < 400)
    begin
      if (link_if.div_reset === 1'b1)
      begin
        cap_codes = link_if.phase_codes;
        cap_en = link_if.channel_enables;
      end
      @(negedge i_clk);
      n++;
    end
    i_sync_check = 1'b0;
    cmp(o_done, 1'b1);
    if (n == 400)
    begin
      err_total++;
      final_report();
    end
  endtask : run_sync
  // check run overrides codes and enables
  task automatic sync_check_case();
    cap_codes = 'x;
    i_phase_codes = 32'h9abcdef1;
    i_channel_enables = 8'h00;
    run_sync(1'b1);
    cmp(cap_codes, {8{sync_check_code}});
    cmp(cap_en, 8'hff);
    cmp(o_div_state, div_reset_state);
  endtask : sync_check_case
  // even or odd codes per channel, last channel off
  task automatic phase_case(input logic [3:0] odd);
    logic [3:0] ph;
    logic [7:0] ei, eq;
    for (int c = 0; c < 8; c++)
      i_phase_codes[4*c +: 4] = 4'(2 * c) + odd;
    i_channel_enables = 8'h7f;
    run_sync(1'b0);
    cmp(link_if.phase_codes, i_phase_codes);
    repeat (16)
    begin
      @(negedge i_clk);
      for (int c = 0; c < 8; c++)
      begin
        ph = {o_div_state, 2'h0} + i_phase_codes[4*c +: 4];
        ei[c] = i_channel_enables[c] & ph[3];
        eq[c] = i_channel_enables[c] & (ph[3] ^ ph[2]);
      end
      cmp(o_ch_i, ei);
      cmp(o_ch_q, eq);
      cmp(o_lo_i, o_div_state[1]);
      cmp(o_lo_q, o_div_state[1] ^ o_div_state[0]);
    end
  endtask : phase_case
  // main sequence
  initial
  begin
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    sync_check_case();
    phase_case(4'h0);
    phase_case(4'h1);
    final_report();
  end
endmodule : testbench
